/* scc_unit.sv */
// sixteen-channel capture/compare array with two reloading time bases
// Notes on behaviour
// - sixteen channels; staggered mode gives eight-cycle resolution
// - two independent 16-bit timers, each with reload
// - timer input: prescaled clock or timer six overflow
// - external count inputs can advance a timer
// - each channel picks timer and capture/compare function
// - one pin per channel: capture input, compare output
// - capture copies assigned timer into channel register
// - each capture raises that channel's interrupt request
// - capture edge: rising, falling or both
// - mode 0 and 1 compare channels match against their timer in the cycle after each timer step
// - mode 0 match: interrupt only, pin untouched
// - mode 1 match: pin toggles on every match
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_unit (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // time base control
  input  wire logic                 stagger,
  input  scc_pkg::scc_tmrcfg_type   tmr_cfg [`SCC_NTMR],
  input  wire logic                 gpt6_ovf,
  input  wire logic [1:0]           ext_cnt,
  // channel control and register access
  input  scc_pkg::scc_chcfg_type    ch_cfg [`SCC_NCH],
  input  wire logic                 wr_en,
  input  wire logic [3:0]           wr_idx,
  input  wire logic [15:0]          wr_data,
  input  wire logic [3:0]           rd_idx,
  // channel pins
  input  wire logic [15:0]          pin_in,
  output logic      [15:0]          pin_out,
  output logic      [15:0]          pin_oe,
  // status
  output logic      [15:0]          irq,
  output logic      [15:0]          rd_data,
  output logic      [15:0]          tmr_q [`SCC_NTMR]
);
  import scc_pkg::*;

  logic [15:0] tmr_ff   [`SCC_NTMR];
  logic [7:0]  pre_ff   [`SCC_NTMR];
  logic [1:0]  es1_ff, es2_ff, es3_ff;
  logic [1:0]  elvl_ff;
  logic [1:0]  tick_ff;
  logic [1:0]  tick;
  logic [1:0]  ext_rise;
  logic [15:0] cc_ff    [`SCC_NCH];
  logic [15:0] ps1_ff, ps2_ff, ps3_ff, plvl_ff;
  logic [15:0] irq_ff, pout_ff, poe_ff, rd_ff;
  logic [15:0] rise, fall, cap_hit, cmp_hit;
  logic [15:0] chan_tmr [`SCC_NCH];

  // external count inputs: three stages, accepted once stages two and three
  // agree, so a single-cycle glitch never counts
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      es1_ff  <= 2'h0;
      es2_ff  <= 2'h0;
      es3_ff  <= 2'h0;
      elvl_ff <= 2'h0;
    end else begin
      es1_ff  <= ext_cnt;
      es2_ff  <= es1_ff;
      es3_ff  <= es2_ff;
      for (int i = 0; i < 2; i++) begin
        if (es2_ff[i] == es3_ff[i]) begin
          elvl_ff[i] <= es3_ff[i];
        end
      end
    end
  end

  genvar t;
  generate
    for (t = 0; t < `SCC_NTMR; t++) begin : g_tmr
      logic [2:0]  exp_w;
      logic [7:0]  mask_w;
      logic        pre_tick;
      logic [15:0] nxt_tmr;
      // staggered mode never lets the prescaler tick faster than every 8 clocks
      assign exp_w    = (stagger && tmr_cfg[t].pre < `SCC_STAG_EXP) ?
                        `SCC_STAG_EXP : tmr_cfg[t].pre;
      assign mask_w   = ~(8'hFF << exp_w);
      assign pre_tick = (pre_ff[t] & mask_w) == mask_w;
      assign ext_rise[t] = (es2_ff[t] == es3_ff[t]) && es3_ff[t] &&
                           !elvl_ff[t];
      assign tick[t]  = tmr_cfg[t].run &&
        ((tmr_cfg[t].src == `SCC_SRC_PRE && pre_tick) ||
         (tmr_cfg[t].src == `SCC_SRC_GPT && gpt6_ovf) ||
         (tmr_cfg[t].src == `SCC_SRC_EXT && ext_rise[t]));
      // wrap loads the reload value rather than zero
      assign nxt_tmr  = (tmr_ff[t] == `SCC_TMR_TOP) ? tmr_cfg[t].reload :
                        tmr_ff[t] + 16'h0001;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pre_ff[t]  <= 8'h00;
          tmr_ff[t]  <= `SCC_TMR_RST;
          tick_ff[t] <= 1'b0;
        end else begin
          pre_ff[t]  <= pre_ff[t] + 8'h01;
          tick_ff[t] <= tick[t];
          if (tick[t]) begin
            tmr_ff[t] <= nxt_tmr;
          end
        end
      end
      assign tmr_q[t] = tmr_ff[t];
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < `SCC_NCH; c++) begin : g_ch
      logic pin_upd;
      logic is_cmp;
      assign chan_tmr[c] = tmr_ff[ch_cfg[c].tsel];
      assign pin_upd = (ps2_ff[c] == ps3_ff[c]) && (ps3_ff[c] != plvl_ff[c]);
      assign rise[c] = pin_upd && ps3_ff[c];
      assign fall[c] = pin_upd && !ps3_ff[c];
      assign cap_hit[c] = (ch_cfg[c].func == SCC_CAP) &&
        ((ch_cfg[c].edge_sel[0] && rise[c]) ||
         (ch_cfg[c].edge_sel[1] && fall[c]));
      // compare only right after the timer moved, so a held value
      // matches once instead of on every clock
      assign cmp_hit[c] = (ch_cfg[c].func == SCC_CMP0 ||
                           ch_cfg[c].func == SCC_CMP1) &&
        tick_ff[ch_cfg[c].tsel] &&
        (chan_tmr[c] == cc_ff[c]);
      assign is_cmp = ch_cfg[c].func >= SCC_CMP0;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          cc_ff[c]   <= `SCC_CC_RST;
          irq_ff[c]  <= 1'b0;
          pout_ff[c] <= 1'b0;
          poe_ff[c]  <= 1'b0;
        end else begin
          // a capture beats a software write in the same cycle
          if (cap_hit[c]) begin
            cc_ff[c] <= chan_tmr[c];
          end else if (wr_en && wr_idx == 4'(c)) begin
            cc_ff[c] <= wr_data;
          end
          irq_ff[c] <= cap_hit[c] || cmp_hit[c];
          if (cmp_hit[c] && ch_cfg[c].func == SCC_CMP1) begin
            pout_ff[c] <= !pout_ff[c];
          end
          poe_ff[c] <= is_cmp;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ps1_ff  <= 16'h0000;
      ps2_ff  <= 16'h0000;
      ps3_ff  <= 16'h0000;
      plvl_ff <= 16'h0000;
      rd_ff   <= 16'h0000;
    end else begin
      ps1_ff  <= pin_in;
      ps2_ff  <= ps1_ff;
      ps3_ff  <= ps2_ff;
      plvl_ff <= (ps2_ff ~^ ps3_ff) & ps3_ff |
                 (ps2_ff ^ ps3_ff) & plvl_ff;
      rd_ff   <= cc_ff[rd_idx];
    end
  end

  assign pin_out = pout_ff;
  assign pin_oe  = poe_ff;
  assign irq     = irq_ff;
  assign rd_data = rd_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_timer_step: assert property (
    tick[0] && tmr_ff[0] != `SCC_TMR_TOP |=>
      tmr_ff[0] == $past(tmr_ff[0]) + 16'h0001)
    else $error("timer 0 did not step by one");
  a_timer_hold: assert property (
    !tick[1] |=> tmr_ff[1] == $past(tmr_ff[1]))
    else $error("timer 1 moved without a tick");
  a_reload_wrap: assert property (
    tick[0] && tmr_ff[0] == `SCC_TMR_TOP |=>
      tmr_ff[0] == $past(tmr_cfg[0].reload))
    else $error("timer 0 did not reload on overflow");
  a_stagger_gap: assert property (
    stagger && tmr_cfg[0].src == `SCC_SRC_PRE && tmr_cfg[0].pre == 3'h0 &&
    tick[0] |=> !tick[0] [*7])
    else $error("staggered tick came sooner than eight clocks");
  a_cap_latch: assert property (
    cap_hit[0] |=> cc_ff[0] == $past(chan_tmr[0]))
    else $error("capture did not latch the timer");
  a_cap_irq: assert property (
    cap_hit[3] |=> irq_ff[3])
    else $error("capture raised no interrupt");
  a_edge_sel: assert property (
    ch_cfg[0].func == SCC_CAP && ch_cfg[0].edge_sel == 2'h1 && fall[0] &&
    !rise[0] |-> !cap_hit[0])
    else $error("falling edge captured in rising-only mode");
  a_mode0_pin: assert property (
    cmp_hit[0] && ch_cfg[0].func == SCC_CMP0 |=>
      irq_ff[0] && pout_ff[0] == $past(pout_ff[0]))
    else $error("mode 0 match touched the pin or gave no interrupt");
  a_mode1_toggle: assert property (
    cmp_hit[0] && ch_cfg[0].func == SCC_CMP1 |=>
      pout_ff[0] != $past(pout_ff[0]))
    else $error("mode 1 match did not toggle the pin");
  a_cmp_match: assert property (
    ch_cfg[2].func == SCC_CMP0 && ch_cfg[2].tsel == 1'b0 && tick_ff[0] &&
    tmr_ff[0] == cc_ff[2] |=> irq_ff[2])
    else $error("compare match missed");
  a_reserved_quiet: assert property (
    ch_cfg[0].func >= SCC_CMP2 |=> !irq_ff[0] ##0 $stable(pout_ff[0]))
    else $error("reserved compare mode took an action");

  c_capture: cover property (cap_hit[0] ##1 irq_ff[0]);
  c_toggle:  cover property (cmp_hit[1] && ch_cfg[1].func == SCC_CMP1);
  c_wrap:    cover property (tick[0] && tmr_ff[0] == `SCC_TMR_TOP);
  c_ext:     cover property (ext_rise[1] && tick[1]);
endmodule

/* scc_params.svh */
// constants for the sixteen-channel capture/compare unit
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
`define SCC_NCH      16
`define SCC_NTMR     2
`define SCC_SRC_PRE  2'h0
`define SCC_SRC_GPT  2'h1
`define SCC_SRC_EXT  2'h2
`define SCC_STAG_EXP 3'h3
`define SCC_TMR_RST  16'h0000
`define SCC_TMR_TOP  16'hFFFF
`define SCC_CC_RST   16'h0000
`endif

/* scc_pkg.sv */
// types for the sixteen-channel capture/compare unit
package scc_pkg;
  typedef enum logic [2:0] {
    SCC_OFF  = 3'h0,
    SCC_CAP  = 3'h1,
    SCC_CMP0 = 3'h2,
    SCC_CMP1 = 3'h3,
    SCC_CMP2 = 3'h4,
    SCC_CMP3 = 3'h5,
    SCC_CMP4 = 3'h6
  } scc_func_type;

  // edge_sel bit 0 selects rising, bit 1 falling
  typedef struct packed {
    scc_func_type func;
    logic [1:0]   edge_sel;
    logic         tsel;
  } scc_chcfg_type;

  typedef struct packed {
    logic        run;
    logic [1:0]  src;
    logic [2:0]  pre;
    logic [15:0] reload;
  } scc_tmrcfg_type;
endpackage

/* scc_pin_model.sv */
// pin model: capture levels from the bench, compare outputs read back
`timescale 1ns/1ps
module scc_pin_model (
  // bench side
  input  wire logic [15:0] lvl,
  // unit side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  output logic      [15:0] pin_in
);
  // a driven pin reads back its own level, as on the real pad
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
endmodule

/* test_scc_unit.sv */
// self-checking bench for the capture/compare unit
`timescale 1ns/1ps
module test_scc_unit;
  import scc_pkg::*;
  logic           clk, nrst, stg, ovf, wr_en;
  logic [1:0]     ext;
  logic [3:0]     wr_idx, rd_idx;
  logic [15:0]    wr_data, lvl, pin_in, pin_out, pin_oe, irq, rd_data;
  logic [15:0]    rl, a, p, k;
  logic [15:0]    tq [2];
  scc_tmrcfg_type tc [2];
  scc_chcfg_type  cc [16];
  scc_func_type   f;
  int             err_total, n_compared, cyc, seed, ch, n, per;
  int             icnt [16];

  scc_unit dut (.clk(clk), .nrst(nrst), .stagger(stg), .tmr_cfg(tc),
    .gpt6_ovf(ovf), .ext_cnt(ext), .ch_cfg(cc), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_data(wr_data), .rd_idx(rd_idx), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .rd_data(rd_data),
    .tmr_q(tq));
  scc_pin_model pins (.lvl(lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // irq is a one-cycle pulse, so count it on every edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 16; i++) icnt[i] <= icnt[i] + int'(irq[i]);
    if (cyc == 80000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("mismatches %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask

  function automatic int nexp(scc_func_type m);
    return (m == SCC_CMP0 || m == SCC_CMP1) ? 3 : 0;
  endfunction

  function automatic int ticks(int pv, logic s);
    return 16 >> ((s && pv < 3) ? 3 : pv);
  endfunction

  initial begin
    seed = 32'hfe6f;
    nrst = 1'b0;
    {stg, ovf, wr_en, ext, wr_idx, rd_idx, wr_data, lvl} = '0;
    rl = 16'hFFE0 | (16'($random(seed)) & 16'h000F);
    tc[0] = '{1'b1, 2'h0, 3'h0, rl};
    tc[1] = '{1'b1, 2'h1, 3'h0, 16'h0000};
    for (int i = 0; i < 16; i++) cc[i] = '{SCC_OFF, 2'h0, 1'b0};
    step(12);
    nrst = 1'b1;
    chk(irq, 16'h0000);
    // timer 0 runs up to the top once, then wraps to the reload value
    n = 0;
    while (tq[0] !== 16'hFFFF && n < 70000) begin
      step(1);
      n++;
    end
    step(1);
    chk(tq[0], rl);
    per = 16'hFFFF - rl + 1;
    // every compare mode over three timer periods: channel 0 first as a
    // corner case, then a random channel (channel 2 for mode 0)
    for (int r = 0; r < 2; r++) begin
      for (int m = 2; m <= 6; m++) begin
        f = scc_func_type'(m);
        ch = (r == 0) ? 0 : (m == 2) ? 2 : $random(seed) & 15;
        wr_idx = 4'(ch);
        wr_data = rl + 16'h0005;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
        cc[ch] = '{f, 2'h0, 1'b0};
        rd_idx = 4'(ch);
        step(per);
        chk(rd_data, rl + 16'h0005);
        a = 16'(icnt[ch]);
        p = pin_out;
        step(3 * per);
        chk(16'(icnt[ch]) - a, 16'(nexp(f)));
        chk(pin_out[ch], p[ch] ^ (f == SCC_CMP1));
        chk(pin_oe[ch], 1'b1);
        cc[ch] = '{SCC_OFF, 2'h0, 1'b0};
      end
    end
    // timer 1 counts overflow pulses of the general timer
    k = 16'($random(seed)) & 16'h000F;
    for (int i = 0; i < k; i++) begin
      ovf = 1'b1;
      step(1);
      ovf = 1'b0;
      step(1);
    end
    chk(tq[1], k);
    // capture on each edge selection, rise then fall of the pin
    for (int e = 1; e <= 3; e++) begin
      ovf = 1'b1;
      step(1);
      ovf = 1'b0;
      k++;
      // channels 0 and 3 are fixed corner cases, the last one is random
      ch = (e == 1) ? 0 : (e == 2) ? 3 : $random(seed) & 15;
      cc[ch] = '{SCC_CAP, 2'(e), 1'b1};
      rd_idx = 4'(ch);
      step(2);
      chk(pin_oe[ch], 1'b0);
      a = 16'(icnt[ch]);
      lvl[ch] = 1'b1;
      step(8);
      lvl[ch] = 1'b0;
      step(8);
      chk(16'(icnt[ch]) - a, 16'(e[0]) + 16'(e[1]));
      chk(rd_data, k);
      cc[ch] = '{SCC_OFF, 2'h0, 1'b0};
    end
    // external count pulses, three sync stages before each tick
    tc[1].src = 2'h2;
    n = 1 + ($random(seed) & 7);
    for (int i = 0; i < n; i++) begin
      ext[1] = 1'b1;
      step(4);
      ext[1] = 1'b0;
      step(4);
    end
    step(4);
    chk(tq[1], k + 16'(n));
    // prescaled clock: divide settings and staggered floor of eight
    tc[1].src = 2'h0;
    for (int pv = 0; pv < 4; pv++) begin
      tc[1].pre = 3'(pv);
      // stagger is only ever switched on here, never dropped inside the
      // eight-clock gap that timer 0 must keep while it is on
      stg = pv[1];
      step(8);
      a = tq[1];
      step(16);
      chk(tq[1] - a, 16'(ticks(pv, stg)));
    end
    final_report();
  end
endmodule
